// file: design/lsrb_regs.v
`timescale 1ns/1ps
`include "lsrb_defines.vh"

// Function
// [R1] ambient result is an unsigned value of 13 to 20 bits
// [R2] ultraviolet result is an unsigned value of 16 to 20 bits
// [R3] results held while a host read targets 0x07 to 0x12
// [R4] conversions staged, copied in once no read targets 0x07 to 0x12
// [R5] ambient bytes at 0x0d..0x0f, top nibble bits 3:0, reset zero
// [R6] ultraviolet bytes at 0x10..0x12, top nibble bits 3:0, reset zero
// [R7] source select bits 5:4: 01 ambient, 11 ultraviolet, others reserved
// [R8] interrupts raised only while enable bit 2 is set, reset off
// [R9] configuration resets to 0x10, reserved bits read zero
// [R10] interrupt after persistence plus one consecutive out-of-range results
// [R11] persistence resets to 0x00, low nibble reserved
// [R12] condition checked whenever the selected channel completes a conversion
// [R13] out of range means above upper or below lower threshold
// [R14] interrupt flag status bit 4, cleared by status read
// [R15] new-data flag status bit 3, cleared by status read
// [R16] persistence counter restarts on in-range result or config rewrite
module lsrb_regs #(
  parameter RES_W = 20
) (
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // conversion results from the measurement engine
  input wire amb_done_i,
  input wire [RES_W-1:0] amb_value_i,
  input wire uv_done_i,
  input wire [RES_W-1:0] uv_value_i,
  // thresholds from the threshold registers
  input wire [RES_W-1:0] thr_upper_i,
  input wire [RES_W-1:0] thr_lower_i,
  // register access from the serial front end
  input wire read_active_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  // register read data and interrupt
  output reg [7:0] reg_rdata_o,
  output reg irq_o
);

  // channel slots: 0 ambient, 1 ultraviolet
  localparam NCH = 2;

  // conversion strobes and values packed so one loop serves both channels
  wire [NCH-1:0] done_vec;
  wire [NCH*RES_W-1:0] value_vec;
  // readable results of both channels, packed the same way
  wire [NCH*RES_W-1:0] shown_vec;

  // visible results split back out for the read mux
  wire [RES_W-1:0] amb_q;
  wire [RES_W-1:0] uv_q;

  // interrupt configuration and persistence, reserved bits held at zero
  reg [7:0] cfg_q;
  reg [7:0] pst_q;

  // consecutive out-of-range count, saturating at fifteen
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;

  // status flags, set by hardware and cleared by a status read
  reg irq_flag_q;
  reg new_flag_q;

  // next read data, taken into the output flop on the next edge
  reg [7:0] rdata_d;

  // comparator input and outcome
  reg hit;
  reg eval;
  reg [RES_W-1:0] sel_val;

  // the result copies freeze while a read sits in the window, the status flags keep updating
  // limitation: a host that parks a read here for ever starves the copy,
  // the newest conversion then waits in staging and older ones are lost
  wire lock = read_active_i && (reg_addr_i >= `LSRB_LOCK_LO) &&
    (reg_addr_i <= `LSRB_LOCK_HI); // [R3]

  // field views of the configuration registers
  wire [1:0] src = cfg_q[`LSRB_SRC_MSB:`LSRB_SRC_LSB];
  wire [3:0] pst = pst_q[`LSRB_PST_MSB:`LSRB_PST_LSB];
  wire irq_en = cfg_q[`LSRB_EN_BIT];

  // decoded register strobes
  wire cfg_wr = reg_wr_i && (reg_addr_i == `LSRB_ADDR_IRQ_CFG);
  wire pst_wr = reg_wr_i && (reg_addr_i == `LSRB_ADDR_IRQ_PST);
  wire stat_rd = reg_rd_i && (reg_addr_i == `LSRB_ADDR_STATUS);

  // a rewrite of either register restarts the persistence count
  wire cfg_touch = cfg_wr || pst_wr;

  // pack the channel inputs, unpack the visible results
  assign done_vec = {uv_done_i, amb_done_i};
  assign value_vec = {uv_value_i, amb_value_i};
  assign amb_q = shown_vec[RES_W-1:0];
  assign uv_q = shown_vec[2*RES_W-1:RES_W];

  // one staging slot and one visible copy per channel
  // a single slot is enough: only the newest result matters once the lock
  // drops, so a deeper buffer would only cost area
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      reg [RES_W-1:0] stage_q;
      reg pend_q;
      reg [RES_W-1:0] shown_q;

      // staging: a fresh conversion overwrites an older uncopied one
      always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stage_q <= `LSRB_RST_RESULT;
          pend_q <= 1'b0;
        end else begin
          if (done_vec[ch]) begin
            stage_q <= value_vec[ch*RES_W +: RES_W]; // [R4] [R1] [R2]
            pend_q <= 1'b1;
          end else if (!lock) begin
            pend_q <= 1'b0; // copied in this cycle
          end
        end
      end

      // visible copy moves only outside a locked read, so bytes never mix
      always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          shown_q <= `LSRB_RST_RESULT; // [R5] [R6]
        end else if (!lock && pend_q) begin
          shown_q <= stage_q; // [R4] [R3]
        end
      end

      assign shown_vec[ch*RES_W +: RES_W] = shown_q;
    end
  endgenerate

  // configuration registers, reserved bits kept zero
  // masking on write keeps the read mux free of per-bit gating
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= `LSRB_RST_IRQ_CFG; // [R9] [R8]
      pst_q <= `LSRB_RST_IRQ_PST; // [R11]
    end else begin
      if (cfg_wr) begin
        cfg_q <= reg_wdata_i & `LSRB_MASK_IRQ_CFG; // [R9]
      end
      if (pst_wr) begin
        pst_q <= reg_wdata_i & `LSRB_MASK_IRQ_PST; // [R11]
      end
    end
  end

  // comparator source and strobe; reserved codes never evaluate
  // raw values are used, not the visible copy, so a lock cannot delay a check
  always @* begin
    sel_val = amb_value_i;
    eval = 1'b0;
    case (src)
      `LSRB_SRC_AMB: begin
        sel_val = amb_value_i; // [R7]
        eval = amb_done_i; // [R12]
      end
      `LSRB_SRC_UV: begin
        sel_val = uv_value_i; // [R7]
        eval = uv_done_i; // [R12]
      end
      default: begin
        eval = 1'b0;
      end
    endcase
    // either side of the threshold window counts
    hit = (sel_val > thr_upper_i) || (sel_val < thr_lower_i); // [R13]
  end

  // persistence counter; saturates so a long run of hits keeps firing
  // the other channel's conversions leave the count alone
  always @* begin
    cnt_d = cnt_q;
    if (cfg_touch) begin
      cnt_d = 4'h0; // [R16]
    end else if (eval) begin
      if (!hit) begin
        cnt_d = 4'h0; // [R16]
      end else if (cnt_q != 4'hf) begin
        cnt_d = cnt_q + 4'h1; // [R10]
      end
    end
  end

  // fire on the hit that completes persistence plus one in a row
  // a rewrite in the same cycle wins, since the count restarts there
  wire fire = eval && hit && !cfg_touch && (cnt_q >= pst) && irq_en; // [R10] [R8]

  // counter state
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // interrupt flag: a set in the clearing cycle wins, so no event is lost
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flag_q <= 1'b0;
    end else if (fire) begin
      irq_flag_q <= 1'b1; // [R14]
    end else if (stat_rd) begin
      irq_flag_q <= 1'b0; // [R14]
    end
  end

  // new-data flag: any finished conversion counts, whatever the source
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      new_flag_q <= 1'b0;
    end else if (|done_vec) begin
      new_flag_q <= 1'b1; // [R15]
    end else if (stat_rd) begin
      new_flag_q <= 1'b0; // [R15]
    end
  end

  // pin level: follows the flag, drops with the clearing read or the enable
  // the flag itself survives a disable, so re-enabling shows it again
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (fire || (irq_flag_q && !stat_rd)) && irq_en; // [R8]
    end
  end

  // read mux; unmapped addresses read zero
  // status shows only the two flags, the other bits stay zero
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr_i)
      `LSRB_ADDR_STATUS: begin
        rdata_d[`LSRB_STAT_IRQ_BIT] = irq_flag_q; // [R14]
        rdata_d[`LSRB_STAT_NEW_BIT] = new_flag_q; // [R15]
      end
      `LSRB_ADDR_AMB_LOW: begin
        rdata_d = amb_q[7:0]; // [R5]
      end
      `LSRB_ADDR_AMB_MID: begin
        rdata_d = amb_q[15:8]; // [R5]
      end
      `LSRB_ADDR_AMB_HIGH: begin
        rdata_d = {4'h0, amb_q[19:16]}; // [R5]
      end
      `LSRB_ADDR_UV_LOW: begin
        rdata_d = uv_q[7:0]; // [R6]
      end
      `LSRB_ADDR_UV_MID: begin
        rdata_d = uv_q[15:8]; // [R6]
      end
      `LSRB_ADDR_UV_HIGH: begin
        rdata_d = {4'h0, uv_q[19:16]}; // [R6]
      end
      `LSRB_ADDR_IRQ_CFG: begin
        rdata_d = cfg_q; // [R9]
      end
      `LSRB_ADDR_IRQ_PST: begin
        rdata_d = pst_q; // [R11]
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // registered read data, so the output comes from a flop
  // costs one cycle of latency after the address settles
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_d;
    end
  end

endmodule // lsrb_regs

// file: shared/lsrb_defines.vh
`ifndef LSRB_DEFINES_VH
`define LSRB_DEFINES_VH
// register byte addresses
`define LSRB_ADDR_STATUS 8'h07
`define LSRB_ADDR_AMB_LOW 8'h0d
`define LSRB_ADDR_AMB_MID 8'h0e
`define LSRB_ADDR_AMB_HIGH 8'h0f
`define LSRB_ADDR_UV_LOW 8'h10
`define LSRB_ADDR_UV_MID 8'h11
`define LSRB_ADDR_UV_HIGH 8'h12
`define LSRB_ADDR_IRQ_CFG 8'h19
`define LSRB_ADDR_IRQ_PST 8'h1a
// locked read window
`define LSRB_LOCK_LO 8'h07
`define LSRB_LOCK_HI 8'h12
// field positions
`define LSRB_SRC_MSB 5
`define LSRB_SRC_LSB 4
`define LSRB_EN_BIT 2
`define LSRB_PST_MSB 7
`define LSRB_PST_LSB 4
`define LSRB_STAT_IRQ_BIT 4
`define LSRB_STAT_NEW_BIT 3
// source codes
`define LSRB_SRC_AMB 2'h1
`define LSRB_SRC_UV 2'h3
// reset values
`define LSRB_RST_RESULT 20'h00000
`define LSRB_RST_IRQ_CFG 8'h10
`define LSRB_RST_IRQ_PST 8'h00
// writable bit masks
`define LSRB_MASK_IRQ_CFG 8'h34
`define LSRB_MASK_IRQ_PST 8'hf0
`endif

// file: tb/lsrb_props.sv
`timescale 1ns/1ps
module lsrb_props #(parameter RES_W = 20) (
  // design ports, watched only
  input wire clock_i,
  input wire rst_n_i,
  input wire amb_done_i,
  input wire [RES_W-1:0] amb_value_i,
  input wire uv_done_i,
  input wire read_active_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // no conversion ends
  sequence quiet; !amb_done_i && !uv_done_i; endsequence
  // read parked on one result byte
  sequence held; read_active_i && reg_addr_i > 8'h0c && reg_addr_i < 8'h13 && $stable(reg_addr_i);
  endsequence
  // low ambient byte addressed, no read open
  sequence idle; !amb_done_i && !read_active_i && reg_addr_i == 8'h0d; endsequence
  a_cfg_resv: assert property (reg_addr_i == 8'h19 |=> !(reg_rdata_o & 8'hcb))
    else $error("cfg reserved");
  a_pst_resv: assert property (reg_addr_i == 8'h1a |=> reg_rdata_o[3:0] == 0)
    else $error("pst reserved");
  a_top_nibble: assert property (
    reg_addr_i inside {8'h0f, 8'h12} |=> reg_rdata_o[7:4] == 0) else $error("top nibble");
  a_lock_hold: assert property (held [*3] |=> $stable(reg_rdata_o))
    else $error("lock moved");
  a_copy_in: assert property (
    amb_done_i ##1 idle [*3] |=> reg_rdata_o == $past(amb_value_i[7:0], 4)) else $error("no copy");
  a_irq_gate: assert property (
    reg_wr_i && reg_addr_i == 8'h19 && !reg_wdata_i[2] |-> ##[1:2] !irq_o) else $error("gate");
  a_irq_cause: assert property (
    $rose(irq_o) |-> $past(amb_done_i || uv_done_i) || $past(reg_wr_i, 2))
    else $error("irq cause");
  a_irq_clear: assert property (
    reg_rd_i && reg_addr_i == 8'h07 ##0 quiet ##1 quiet |=> !irq_o) else $error("irq clear");
endmodule // lsrb_props

bind lsrb_regs lsrb_props #(.RES_W(RES_W)) props_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .amb_done_i(amb_done_i), .amb_value_i(amb_value_i), .uv_done_i(uv_done_i),
  .read_active_i(read_active_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

// file: tb/lsrb_host.sv
`timescale 1ns/1ps
module lsrb_host (
  // clock and read data
  input wire clock_i,
  input wire [7:0] reg_rdata_i,
  // register access
  output reg read_active_o = 0,
  output reg [7:0] reg_addr_o = 0,
  output reg reg_wr_o = 0,
  output reg [7:0] reg_wdata_o = 0,
  output reg reg_rd_o = 0
);
  // pointer stays after a transfer, as a register pointer does
  task wr(input [7:0] a, input [7:0] x);
    @(posedge clock_i) #1;
    reg_addr_o = a;
    reg_wdata_o = x;
    reg_wr_o = 1;
    @(posedge clock_i) #1;
    reg_wr_o = 0;
    reg_wdata_o = ~x;
  endtask
  // read kept open long enough for a fresh result to land
  task rd(input [7:0] a, output [7:0] x);
    @(posedge clock_i) #1;
    reg_addr_o = a;
    read_active_o = 1;
    repeat (3) @(posedge clock_i);
    #1 x = reg_rdata_i;
    reg_rd_o = 1;
    @(posedge clock_i) #1;
    reg_rd_o = 0;
    read_active_o = 0;
  endtask
endmodule // lsrb_host

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clock_i = 0;
  reg rst_n_i = 0;
  reg amb_done_i = 0;
  reg uv_done_i = 0;
  reg [19:0] amb_value_i = 0;
  reg [19:0] uv_value_i = 0;
  wire read_active_i, reg_wr_i, reg_rd_i, irq_o;
  wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  integer n_errors = 0, num_checks = 0, seed = 47551, cyc = 0, i, k;
  integer m [0:31];
  reg [7:0] d, old;
  reg [19:0] v;
  reg [19:0] thr_up = 20'h00fff, thr_lo = 20'h00000;
  // 200 MHz
  always #2.5 clock_i = ~clock_i;
  lsrb_regs dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .amb_done_i(amb_done_i),
    .amb_value_i(amb_value_i), .uv_done_i(uv_done_i), .uv_value_i(uv_value_i),
    .thr_upper_i(thr_up), .thr_lower_i(thr_lo), .read_active_i(read_active_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  lsrb_host host_u (.clock_i(clock_i), .reg_rdata_i(reg_rdata_o), .read_active_o(read_active_i),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));
  task chk(input [63:0] nm, input [7:0] seen, input [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one conversion; data lines show junk once done drops
  task conv(input integer ch, input [19:0] x);
    @(posedge clock_i) #1;
    if (ch) {uv_done_i, uv_value_i} = {1'b1, x};
    else {amb_done_i, amb_value_i} = {1'b1, x};
    m[13 + 3 * ch] = x[7:0];
    m[14 + 3 * ch] = x[15:8];
    m[15 + 3 * ch] = x[19:16];
    @(posedge clock_i) #1;
    {amb_done_i, uv_done_i, amb_value_i, uv_value_i} = {2'b00, ~x, ~x};
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  // all result and irq registers against the model
  task sweep;
    for (i = 13; i < 21; i = i + 1) begin
      k = i < 19 ? i : i + 6;
      host_u.rd(k[7:0], d);
      chk("reg", d, m[k][7:0]);
    end
  endtask
  initial begin
    for (i = 0; i < 32; i = i + 1) m[i] = 0;
    m[25] = 8'h10;
    repeat (6) @(posedge clock_i);
    #1 rst_n_i = 1;
    sweep;
    // writes to read-only and reserved bits go nowhere
    for (i = 0; i < 6; i = i + 1) begin
      k = i % 3 ? 8'h18 + i % 3 : 8'h0d;
      d = 8'($random(seed));
      host_u.wr(k[7:0], d);
      if (k == 25) m[25] = d & 8'h34;
      if (k == 26) m[26] = d & 8'hf0;
    end
    conv(0, 20'($random(seed)));
    conv(1, 20'($random(seed)));
    sweep;
    $display("register test done");
    // result frozen while a read sits in the window
    old = m[13][7:0];
    v = 20'($random(seed));
    fork
      host_u.rd(8'h0d, d);
      conv(0, v);
    join
    chk("locked", d, old);
    host_u.rd(8'h0d, d);
    chk("copied", d, v[7:0]);
    conv(0, ~v);
    $display("lock test done");
    // persistence of one, so two hits per source, other channel ignored
    host_u.wr(8'h1a, 8'h10);
    for (i = 0; i < 2; i = i + 1) begin
      host_u.wr(8'h19, i ? 8'h34 : 8'h14);
      host_u.rd(8'h07, d);
      conv(1 - i, 20'hfffff);
      conv(i, 20'hfffff);
      chk("irq1", {7'h00, irq_o}, 8'h00);
      conv(i, 20'hfffff);
      chk("irq2", {7'h00, irq_o}, 8'h01);
      host_u.rd(8'h07, d);
      chk("status", d & 8'h18, 8'h18);
      @(posedge clock_i) #1;
      chk("clear", {7'h00, irq_o}, 8'h00);
    end
    // below the lower limit counts too; an in-range result restarts the count
    thr_lo = 20'h00100;
    conv(1, 20'h00800);
    conv(1, 20'h00010);
    chk("lowone", {7'h00, irq_o}, 8'h00);
    conv(1, 20'h00010);
    chk("lowtwo", {7'h00, irq_o}, 8'h01);
    host_u.rd(8'h07, d);
    host_u.wr(8'h19, 8'h30);
    conv(1, 20'hfffff);
    conv(1, 20'hfffff);
    chk("off", {7'h00, irq_o}, 8'h00);
    $display("irq test done");
    summarize;
  end
  // hang guard, far beyond the run length
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
endmodule // testbench
